// ===== include/eeprom_mem_if.sv
// port between the bus side logic and the memory array
`timescale 1ns/1ps
interface eeprom_mem_if;
  logic we;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport ctrl (output we, output addr, output wdata, input rdata);
  modport store (input we, input addr, input wdata, output rdata);
endinterface

// ===== include/supervised_i2c_eeprom_map.svh
// constants of the supervised i2c eeprom front end
`ifndef SUPERVISED_I2C_EEPROM_MAP_SVH
`define SUPERVISED_I2C_EEPROM_MAP_SVH

// system clock
`define CLK_PERIOD_NS 40

// reset supervisor timing
`define RST_TIMEOUT_MS 200
`define RST_TIMEOUT_CYC ((`RST_TIMEOUT_MS * 1000000) / `CLK_PERIOD_NS)
`define RST_CNT_W 23
`define MR_GLITCH_NS 100
`define MR_GLITCH_CYC ((`MR_GLITCH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MR_CNT_W 2
`define PWR_UP_TO_ACCESS_MS 270

// internal write cycle
`define WRITE_CYCLE_MS 5
`define WRITE_CYCLE_CYC ((`WRITE_CYCLE_MS * 1000000) / `CLK_PERIOD_NS)
`define WC_CNT_W 17

// synchroniser reset pattern: supply_low, mr, pin high; stop, wr_done low
`define SYNC_W 5
`define SYNC_RST_VAL 5'h07

// slave addressing and memory
`define DEV_TYPE_CODE 4'ha
`define MEM_DEPTH 256
`define BYTE_IDX_DATA 2'h2

`endif

// ===== include/supervised_i2c_eeprom_pkg.sv
// types of the supervised i2c eeprom front end
package supervised_i2c_eeprom_pkg;

  // reset supervisor states
  typedef enum logic [1:0] {RS_HOLD, RS_TIME, RS_OFF} reset_state_t;

  // bus side states
  typedef enum logic [2:0] {LK_IDLE, LK_RX, LK_RX_ACK, LK_TX, LK_TX_ACK} link_state_t;

endpackage

// ===== rtl/eeprom_array.sv
// byte wide memory array with registered read data
`timescale 1ns/1ps
`include "supervised_i2c_eeprom_map.svh"
module eeprom_array (
  // clock of the bus side
  input wire logic clk,
  // access port
  eeprom_mem_if.store port
);

  logic [7:0] mem [`MEM_DEPTH];
  logic [7:0] rdata_reg;

  // write on request, read every edge
  always_ff @(posedge clk) begin
    if (port.we) begin
      mem[port.addr] <= port.wdata;
    end
    rdata_reg <= mem[port.addr];
  end

  assign port.rdata = rdata_reg;

endmodule

// ===== rtl/supervised_i2c_eeprom_front.sv
// reset supervisor and i2c slave front end of a serial eeprom
`timescale 1ns/1ps
`include "supervised_i2c_eeprom_map.svh"
// Function
// - resets held through power-up timeout
// - release reset outputs after timeout
// - assert resets when supply drops
// - reset pin falling edge restarts timeout
// - short external pin pulse still full timeout
// - manual reset held, then one timeout
// - ignore manual reset glitches under 100ns
// - reset aborts and refuses bus transactions
// - no write start in reset, no abort
// - write protect blocks every array write
// - sda changes with scl high mark conditions
// - start is sda fall, scl high
// - stop is sda rise, scl high
// - match upper address nibble to 1010
// - last address bit selects direction
// - acknowledge only a matching address
// - receiver pulls sda low on ninth clock
// - acknowledge the word address byte, and data bytes only when not write protected
// - read until master withholds acknowledge
// - no address acknowledge during write cycle
module supervised_i2c_eeprom_front #(
  parameter int RST_TIMEOUT_CYC = `RST_TIMEOUT_CYC,
  parameter int WRITE_CYCLE_CYC = `WRITE_CYCLE_CYC
) (
  // system clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // i2c bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // supply monitor and manual reset
  input wire logic supply_low,
  input wire logic manual_reset_n,
  // active low reset pin, two-way
  input wire logic rst_pin_in,
  output logic rst_lo_out,
  output logic rst_lo_oe,
  // active high reset pin
  output logic rst_hi_out,
  output logic rst_hi_oe,
  // write protect and status
  input wire logic write_protect,
  output logic write_busy
);

  ////////////////////////////////////////////////////////////////////////////////
  // system clock side

  logic [`SYNC_W-1:0] sync_a_reg;
  logic [`SYNC_W-1:0] sync_b_reg;
  logic supply_s;
  logic mr_s;
  logic pin_s;
  logic stop_s;
  logic wr_s;
  logic pin_d_reg;
  logic stop_d_reg;
  logic pin_fall;
  logic stop_ev;
  logic [`MR_CNT_W-1:0] mr_cnt_reg;
  logic mr_low_reg;
  supervised_i2c_eeprom_pkg::reset_state_t rs_state_reg;
  logic [`RST_CNT_W-1:0] rst_cnt_reg;
  logic rst_active_reg;
  logic busy_reg;
  logic [`WC_CNT_W-1:0] busy_cnt_reg;
  logic stop_tog_reg;
  logic wr_done_reg;

  // two flops on every input from outside this clock
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sync_a_reg <= `SYNC_RST_VAL;
      sync_b_reg <= `SYNC_RST_VAL;
    end else begin
      sync_a_reg <= {wr_done_reg, stop_tog_reg, rst_pin_in, manual_reset_n, supply_low};
      sync_b_reg <= sync_a_reg;
    end
  end

  assign supply_s = sync_b_reg[0];
  assign mr_s = sync_b_reg[1];
  assign pin_s = sync_b_reg[2];
  assign stop_s = sync_b_reg[3];
  assign wr_s = sync_b_reg[4];

  // edge detectors on the synchronised levels
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_d_reg <= 1'h1;
      stop_d_reg <= 1'h0;
    end else begin
      pin_d_reg <= pin_s;
      stop_d_reg <= stop_s;
    end
  end

  // our own drive of the pin is not an external request
  assign pin_fall = pin_d_reg & ~pin_s & ~rst_lo_oe;
  assign stop_ev = stop_s ^ stop_d_reg;

  // manual reset glitch filter, needs a run of low samples
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mr_cnt_reg <= '0;
      mr_low_reg <= 1'h0;
    end else if (mr_s) begin
      mr_cnt_reg <= '0;
      mr_low_reg <= 1'h0;
    end else if (mr_cnt_reg == `MR_CNT_W'(`MR_GLITCH_CYC - 1)) begin
      mr_low_reg <= 1'h1;
    end else begin
      mr_cnt_reg <= mr_cnt_reg + `MR_CNT_W'(1);
    end
  end

  // reset state machine: hold while a source is active, then time out
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rs_state_reg <= supervised_i2c_eeprom_pkg::RS_HOLD;
      rst_cnt_reg <= '0;
    end else if (supply_s || mr_low_reg) begin
      rs_state_reg <= supervised_i2c_eeprom_pkg::RS_HOLD;
      rst_cnt_reg <= '0;
    end else if (pin_fall) begin
      rs_state_reg <= supervised_i2c_eeprom_pkg::RS_TIME;
      rst_cnt_reg <= '0;
    end else begin
      case (rs_state_reg)
        supervised_i2c_eeprom_pkg::RS_HOLD: begin
          rs_state_reg <= supervised_i2c_eeprom_pkg::RS_TIME;
          rst_cnt_reg <= '0;
        end
        supervised_i2c_eeprom_pkg::RS_TIME: begin
          if (rst_cnt_reg == `RST_CNT_W'(RST_TIMEOUT_CYC - 1)) begin
            rs_state_reg <= supervised_i2c_eeprom_pkg::RS_OFF;
          end else begin
            rst_cnt_reg <= rst_cnt_reg + `RST_CNT_W'(1);
          end
        end
        default: begin
          rs_state_reg <= supervised_i2c_eeprom_pkg::RS_OFF;
        end
      endcase
    end
  end

  // one reset state drives both open-drain pins
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_active_reg <= 1'h1;
      rst_hi_out <= 1'h1;
      rst_hi_oe <= 1'h1;
      rst_lo_out <= 1'h0;
      rst_lo_oe <= 1'h1;
    end else begin
      rst_active_reg <= rs_state_reg != supervised_i2c_eeprom_pkg::RS_OFF;
      rst_hi_out <= rs_state_reg != supervised_i2c_eeprom_pkg::RS_OFF;
      rst_lo_out <= rs_state_reg == supervised_i2c_eeprom_pkg::RS_OFF;
      rst_hi_oe <= rs_state_reg != supervised_i2c_eeprom_pkg::RS_OFF;
      rst_lo_oe <= rs_state_reg != supervised_i2c_eeprom_pkg::RS_OFF;
    end
  end

  // internal write cycle, started by the stop of a write, never cut short
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      busy_reg <= 1'h0;
      busy_cnt_reg <= '0;
    end else if (busy_reg) begin
      if (busy_cnt_reg == `WC_CNT_W'(WRITE_CYCLE_CYC - 1)) begin
        busy_reg <= 1'h0;
      end else begin
        busy_cnt_reg <= busy_cnt_reg + `WC_CNT_W'(1);
      end
    end else if (stop_ev && wr_s && !rst_active_reg) begin
      busy_reg <= 1'h1;
      busy_cnt_reg <= '0;
    end
  end

  assign write_busy = busy_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // bus side, clocked by scl

  logic link_rst_n;
  logic start_tog_reg;
  logic start_seen_reg;
  logic [1:0] busy_sync_reg;
  logic [1:0] wp_sync_reg;
  supervised_i2c_eeprom_pkg::link_state_t lk_state_reg;
  logic [2:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] rx_byte;
  logic [1:0] byte_idx_reg;
  logic read_dir_reg;
  logic ack_go_reg;
  logic [7:0] word_addr_reg;
  logic rx_last;
  eeprom_mem_if mem_bus ();

  // a running reset clears the bus side at once and keeps it idle
  assign link_rst_n = arst_n & ~rst_active_reg;

  // start: sda falls while scl is high
  always_ff @(negedge sda_in or negedge link_rst_n) begin
    if (!link_rst_n) begin
      start_tog_reg <= 1'h0;
    end else if (scl_in) begin
      start_tog_reg <= ~start_tog_reg;
    end
  end

  // stop: sda rises while scl is high
  always_ff @(posedge sda_in or negedge arst_n) begin
    if (!arst_n) begin
      stop_tog_reg <= 1'h0;
    end else if (scl_in) begin
      stop_tog_reg <= ~stop_tog_reg;
    end
  end

  // busy and write protect levels brought into the bus clock
  always_ff @(posedge scl_in or negedge link_rst_n) begin
    if (!link_rst_n) begin
      busy_sync_reg <= 2'h0;
      wp_sync_reg <= 2'h3;
    end else begin
      busy_sync_reg <= {busy_sync_reg[0], busy_reg};
      wp_sync_reg <= {wp_sync_reg[0], write_protect};
    end
  end

  assign rx_byte = {shift_reg[6:0], sda_in};
  assign rx_last = lk_state_reg == supervised_i2c_eeprom_pkg::LK_RX && bit_cnt_reg == 3'h7;

  // receive, acknowledge and transmit sequencing on rising scl
  always_ff @(posedge scl_in or negedge link_rst_n) begin
    if (!link_rst_n) begin
      start_seen_reg <= 1'h0;
      lk_state_reg <= supervised_i2c_eeprom_pkg::LK_IDLE;
      bit_cnt_reg <= 3'h0;
      shift_reg <= 8'h00;
      byte_idx_reg <= 2'h0;
      read_dir_reg <= 1'h0;
      ack_go_reg <= 1'h0;
      word_addr_reg <= 8'h00;
      wr_done_reg <= 1'h0;
    end else if (start_seen_reg != start_tog_reg) begin
      start_seen_reg <= start_tog_reg;
      lk_state_reg <= supervised_i2c_eeprom_pkg::LK_RX;
      bit_cnt_reg <= 3'h1;
      shift_reg <= {7'h00, sda_in};
      byte_idx_reg <= 2'h0;
      ack_go_reg <= 1'h0;
      wr_done_reg <= 1'h0;
    end else begin
      case (lk_state_reg)
        supervised_i2c_eeprom_pkg::LK_RX: begin
          shift_reg <= rx_byte;
          bit_cnt_reg <= bit_cnt_reg + 3'h1;
          if (rx_last) begin
            lk_state_reg <= supervised_i2c_eeprom_pkg::LK_RX_ACK;
            if (byte_idx_reg == 2'h0) begin
              ack_go_reg <= rx_byte[7:4] == `DEV_TYPE_CODE && !busy_sync_reg[1];
              read_dir_reg <= rx_byte[0];
            end else if (byte_idx_reg == 2'h1) begin
              ack_go_reg <= 1'h1;
              word_addr_reg <= rx_byte;
            end else begin
              ack_go_reg <= !wp_sync_reg[1];
              if (!wp_sync_reg[1]) begin
                word_addr_reg <= word_addr_reg + 8'h01;
                wr_done_reg <= 1'h1;
              end
            end
          end
        end
        supervised_i2c_eeprom_pkg::LK_RX_ACK: begin
          bit_cnt_reg <= 3'h0;
          if (!ack_go_reg) begin
            lk_state_reg <= supervised_i2c_eeprom_pkg::LK_IDLE;
          end else if (read_dir_reg && byte_idx_reg == 2'h0) begin
            lk_state_reg <= supervised_i2c_eeprom_pkg::LK_TX;
          end else begin
            lk_state_reg <= supervised_i2c_eeprom_pkg::LK_RX;
            if (byte_idx_reg != `BYTE_IDX_DATA) begin
              byte_idx_reg <= byte_idx_reg + 2'h1;
            end
          end
        end
        supervised_i2c_eeprom_pkg::LK_TX: begin
          bit_cnt_reg <= bit_cnt_reg + 3'h1;
          if (bit_cnt_reg == 3'h7) begin
            lk_state_reg <= supervised_i2c_eeprom_pkg::LK_TX_ACK;
            word_addr_reg <= word_addr_reg + 8'h01;
          end
        end
        supervised_i2c_eeprom_pkg::LK_TX_ACK: begin
          bit_cnt_reg <= 3'h0;
          if (!sda_in) begin
            lk_state_reg <= supervised_i2c_eeprom_pkg::LK_TX;
          end else begin
            lk_state_reg <= supervised_i2c_eeprom_pkg::LK_IDLE;
          end
        end
        default: begin
          lk_state_reg <= supervised_i2c_eeprom_pkg::LK_IDLE;
        end
      endcase
    end
  end

  // sda drive changes only on falling scl
  always_ff @(negedge scl_in or negedge link_rst_n) begin
    if (!link_rst_n) begin
      sda_oe <= 1'h0;
      sda_out <= 1'h0;
    end else begin
      sda_out <= 1'h0;
      case (lk_state_reg)
        supervised_i2c_eeprom_pkg::LK_RX_ACK: begin
          sda_oe <= ack_go_reg;
        end
        supervised_i2c_eeprom_pkg::LK_TX: begin
          sda_oe <= ~mem_bus.rdata[3'h7 - bit_cnt_reg];
        end
        default: begin
          sda_oe <= 1'h0;
        end
      endcase
    end
  end

  // array access: write on the last bit of an unprotected data byte
  assign mem_bus.we = rx_last && byte_idx_reg == `BYTE_IDX_DATA && !wp_sync_reg[1];
  assign mem_bus.addr = word_addr_reg;
  assign mem_bus.wdata = rx_byte;

  eeprom_array u_array (
    .clk(scl_in),
    .port(mem_bus.store)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  sequence supply_drop_s;
    $rose(supply_s) ##2 1'h1; // state one edge, output register the next
  endsequence

  sequence timeout_end_s;
    rs_state_reg == supervised_i2c_eeprom_pkg::RS_TIME
      && rst_cnt_reg == `RST_CNT_W'(RST_TIMEOUT_CYC - 1) && !supply_s && !mr_low_reg && !pin_fall;
  endsequence

  hi_lo_mirror_a: assert property (@(posedge clk) disable iff (!arst_n)
    rst_hi_out == !rst_lo_out && rst_hi_oe == rst_lo_oe)
    else $error("reset outputs not complementary");

  supply_reset_a: assert property (@(posedge clk) disable iff (!arst_n)
    supply_drop_s |-> rst_hi_out && rst_lo_oe)
    else $error("supply drop did not assert reset");

  timeout_release_a: assert property (@(posedge clk) disable iff (!arst_n)
    $fell(rst_active_reg) |-> $past(rst_cnt_reg, 2) == `RST_CNT_W'(RST_TIMEOUT_CYC - 1))
    else $error("reset released before full timeout");

  oe_release_a: assert property (@(posedge clk) disable iff (!arst_n)
    timeout_end_s |-> ##2 !rst_hi_oe && !rst_lo_oe)
    else $error("reset outputs still driven after timeout");

  pin_restart_a: assert property (@(posedge clk) disable iff (!arst_n)
    pin_fall && !supply_s && !mr_low_reg |=> rs_state_reg == supervised_i2c_eeprom_pkg::RS_TIME
      && rst_cnt_reg == '0 ##1 rst_lo_oe)
    else $error("pin fall did not restart timeout");

  mr_glitch_a: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(mr_low_reg) |-> !$past(mr_s, 1) && !$past(mr_s, 2) && !$past(mr_s, 3))
    else $error("manual reset taken from short glitch");

  mr_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
    mr_low_reg |=> rs_state_reg == supervised_i2c_eeprom_pkg::RS_HOLD ##1 rst_hi_out)
    else $error("manual reset low did not hold reset");

  busy_keep_a: assert property (@(posedge clk) disable iff (!arst_n)
    busy_reg && rst_active_reg && busy_cnt_reg != `WC_CNT_W'(WRITE_CYCLE_CYC - 1) |=> busy_reg)
    else $error("write cycle cut short by reset");

  busy_nack_a: assert property (@(posedge scl_in) disable iff (!link_rst_n)
    rx_last && byte_idx_reg == 2'h0 && busy_sync_reg[1] |=> !ack_go_reg)
    else $error("address acknowledged during write cycle");

  read_nack_a: assert property (@(posedge scl_in) disable iff (!link_rst_n)
    lk_state_reg == supervised_i2c_eeprom_pkg::LK_TX_ACK && sda_in
      && start_seen_reg == start_tog_reg |=> lk_state_reg == supervised_i2c_eeprom_pkg::LK_IDLE)
    else $error("read continued without acknowledge");

endmodule

// ===== verification/i2c_master_model.sv
// i2c bus master model driving scl and its open-drain share of sda
`timescale 1ns/1ps
module i2c_master_model (
  // resolved data line
  input wire logic sda,
  // master pins
  output logic scl,
  output logic sda_drv
);
  localparam int HALF = 16;

  // idle bus: both lines released, scl stands still between frames
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end

  //////////////////////////////////////////////////////////////////////////////
  // one bit out, data moved only while scl low
  task automatic bit_out(input logic b);
    sda_drv = b;
    #(HALF / 2) scl = 1'b1;
    #HALF scl = 1'b0;
    #(HALF / 2);
  endtask

  // one bit in, sampled mid high phase
  task automatic bit_in(output logic b);
    sda_drv = 1'b1;
    #(HALF / 2) scl = 1'b1;
    #(HALF / 2) b = sda;
    #(HALF / 2) scl = 1'b0;
    #(HALF / 2);
  endtask

  // start or repeated start: sda falls while scl high
  task automatic start();
    sda_drv = 1'b1;
    #(HALF / 2) scl = 1'b1;
    #HALF sda_drv = 1'b0;
    #HALF scl = 1'b0;
    #(HALF / 2);
  endtask

  // stop: sda rises while scl high, bus left idle
  task automatic stop();
    sda_drv = 1'b0;
    #(HALF / 2) scl = 1'b1;
    #HALF sda_drv = 1'b1;
    #HALF;
  endtask

  // byte out msb first, then the receiver's ack slot
  task automatic write_byte(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      bit_out(d[i]);
    end
    bit_in(b);
    ack = ~b;
  endtask

  // byte in, then our ack or nack
  task automatic read_byte(input logic ack, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) begin
      bit_in(d[i]);
    end
    bit_out(~ack);
  endtask
endmodule

// ===== verification/supervised_i2c_eeprom_front_test.sv
// self-checking bench of the supervised i2c eeprom front end
`timescale 1ns/1ps
`define CHECK(act, exp) \
  begin \
    comparisons++; \
    if ((act) !== (exp)) begin \
      n_errors++; \
      $display("[FAIL] t=%0t got=%h exp=%h", $time, (act), (exp)); \
    end \
  end
module supervised_i2c_eeprom_front_test;
  localparam int TMO = 50;
  localparam int WCYC = 40;
  logic clk, arst_n, supply_low, manual_reset_n, ext_rst_n, write_protect;
  logic scl, sda_drv, sda_out, sda_oe, write_busy;
  logic rst_lo_out, rst_lo_oe, rst_hi_out, rst_hi_oe;
  wire logic sda;
  wire logic rst_pin_in;
  int n_errors = 0;
  int comparisons = 0;
  logic ack;
  logic [7:0] rd;
  time t0;

  // open-drain wires with pull-ups
  assign sda = (sda_oe ? sda_out : 1'b1) & sda_drv;
  assign rst_pin_in = (rst_lo_oe ? rst_lo_out : 1'b1) & ext_rst_n;

  supervised_i2c_eeprom_front #(.RST_TIMEOUT_CYC(TMO), .WRITE_CYCLE_CYC(WCYC)) i_dut (
    .clk(clk), .arst_n(arst_n), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .supply_low(supply_low), .manual_reset_n(manual_reset_n),
    .rst_pin_in(rst_pin_in), .rst_lo_out(rst_lo_out), .rst_lo_oe(rst_lo_oe),
    .rst_hi_out(rst_hi_out), .rst_hi_oe(rst_hi_oe), .write_protect(write_protect),
    .write_busy(write_busy)
  );

  i2c_master_model i_master (.sda(sda), .scl(scl), .sda_drv(sda_drv));

  // system clock 25 MHz
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  //////////////////////////////////////////////////////////////////////////////
  // verdict and end of run
  task automatic complete_run();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // k edges, then settle
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  // bounded wait on reset release (sel 0) or busy level (sel 1)
  task automatic wait_for(input bit sel, input logic lvl);
    int cnt;
    cnt = 0;
    while ((sel ? write_busy : rst_hi_oe) !== lvl && cnt < 400) begin
      tick(1);
      cnt++;
    end
    if (cnt >= 400) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, cnt, lvl);
      complete_run();
    end
  endtask

  // start and one address byte with expected ack
  task automatic addr_only(input logic [7:0] a, input logic exp);
    i_master.start();
    i_master.write_byte(a, ack);
    `CHECK(ack, exp)
  endtask

  // byte write frame
  task automatic write_mem(input logic [7:0] a, input logic [7:0] d, input logic exp);
    addr_only(8'ha0, 1'b1);
    i_master.write_byte(a, ack);
    `CHECK(ack, 1'b1)
    i_master.write_byte(d, ack);
    `CHECK(ack, exp)
    i_master.stop();
  endtask

  // random read of two bytes, nack on the second
  task automatic read_mem(input logic [7:0] a, input logic [7:0] e0, input logic [7:0] e1);
    addr_only(8'ha0, 1'b1);
    i_master.write_byte(a, ack);
    `CHECK(ack, 1'b1)
    addr_only(8'ha1, 1'b1);
    i_master.read_byte(1'b1, rd);
    `CHECK(rd, e0)
    i_master.read_byte(1'b0, rd);
    `CHECK(rd, e1)
    `CHECK(sda_oe, 1'b0)
    i_master.stop();
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    arst_n = 1'b0;
    supply_low = 1'b0;
    manual_reset_n = 1'b1;
    ext_rst_n = 1'b1;
    write_protect = 1'b0;
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    t0 = $time;
    tick(TMO - 10);
    `CHECK({rst_hi_oe, rst_hi_out, rst_lo_oe, rst_lo_out}, 4'b1110)
    wait_for(1'b0, 1'b0);
    `CHECK(($time - t0) >= TMO * 40, 1'b1)
    `CHECK({rst_lo_oe, rst_lo_out, rst_hi_out}, 3'b010)
    // first frame only after release; busy refuses the address
    write_mem(8'h10, 8'h5a, 1'b1);
    wait_for(1'b1, 1'b1);
    addr_only(8'ha0, 1'b0);
    i_master.stop();
    wait_for(1'b1, 1'b0);
    write_mem(8'h11, 8'hc3, 1'b1);
    wait_for(1'b1, 1'b1);
    wait_for(1'b1, 1'b0);
    read_mem(8'h10, 8'h5a, 8'hc3);
    // every device type code, only one matches
    for (int i = 0; i < 16; i++) begin
      addr_only({4'(i), 4'h0}, 1'(i == 10));
      i_master.stop();
    end
    // protected write refused, array unchanged
    @(posedge clk) write_protect <= 1'b1;
    write_mem(8'h10, 8'hff, 1'b0);
    tick(10);
    `CHECK(write_busy, 1'b0)
    @(posedge clk) write_protect <= 1'b0;
    read_mem(8'h10, 8'h5a, 8'hc3);
    // supply drop asserts reset and refuses frames
    @(posedge clk) supply_low <= 1'b1;
    tick(5);
    `CHECK({rst_hi_oe, rst_hi_out, rst_lo_oe, rst_lo_out}, 4'b1110)
    addr_only(8'ha0, 1'b0);
    i_master.stop();
    @(posedge clk) supply_low <= 1'b0;
    t0 = $time;
    wait_for(1'b0, 1'b0);
    `CHECK(($time - t0) >= TMO * 40, 1'b1)
    // short pin pulse in mid frame aborts it, full timeout follows
    addr_only(8'ha0, 1'b1);
    @(posedge clk) ext_rst_n <= 1'b0;
    t0 = $time;
    repeat (3) @(posedge clk);
    ext_rst_n <= 1'b1;
    tick(4);
    `CHECK(rst_hi_out, 1'b1)
    i_master.write_byte(8'h20, ack);
    `CHECK(ack, 1'b0)
    i_master.stop();
    wait_for(1'b0, 1'b0);
    `CHECK(($time - t0) >= TMO * 40, 1'b1)
    // manual reset glitch ignored, long press held then timed
    @(posedge clk) manual_reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    manual_reset_n <= 1'b1;
    tick(12);
    `CHECK(rst_hi_oe, 1'b0)
    @(posedge clk) manual_reset_n <= 1'b0;
    tick(TMO + 20);
    `CHECK(rst_hi_out, 1'b1)
    @(posedge clk) manual_reset_n <= 1'b1;
    t0 = $time;
    wait_for(1'b0, 1'b0);
    `CHECK(($time - t0) >= TMO * 40, 1'b1)
    // write cycle runs on through a reset
    write_mem(8'h12, 8'h3c, 1'b1);
    wait_for(1'b1, 1'b1);
    t0 = $time;
    @(posedge clk) supply_low <= 1'b1;
    repeat (8) @(posedge clk);
    supply_low <= 1'b0;
    wait_for(1'b1, 1'b0);
    `CHECK(($time - t0) / 40 inside {[WCYC - 1:WCYC + 1]}, 1'b1)
    wait_for(1'b0, 1'b0);
    read_mem(8'h11, 8'hc3, 8'h3c);
    complete_run();
  end
endmodule
